// File: src/pcib_pkg.sv
// Functional notes
// - Log 32-bit PCI address when any of six PCI-side errors flags.
// - PCI error address locked while a PCI flag is set; sets lost instead.
// - All 32 address bits are logged, so every documented subset is valid.
// - System-bus address bits 33:6 logged in bits 31:4; bits 3:0 read zero.
// - System-bus error address locked while its flags are set; lost is set.
// - Translated bases hold address 32:10 in bits 31:9, drive window base.
// - Address extension zero always reads zero; writes are ignored.
// - Extension one bits 31:27 drive PCI address 31:27 for memory reads.
// - Eight read-only tag registers: page tag 31:13, valid bit 12.
// - Eight read-only data registers: CPU page 32:13 in bits 20:1.
// - Any write to the flush register invalidates every map cache entry except one filled in that cycle.
// - Both fetch commands get the OK acknowledge code one cycle later, but only while no read is in progress.
// - Read block to PCI space derives address, byte enables, command.
// - Master requests PCI and waits; no request when already parked.
// - DMA read arriving before grant preempts the pending CPU read.
// - On grant drive address and command; request internal data bus.
// - Successful read data ends the transaction and releases PCI.
// - Abort or parity error ends the read; data marked erroneous.
// - Retry drops internal bus request, idles, reissues when PCI idle.
// - With internal bus grant, data moves to read buffer, request clears.
// - Without grant data is held locally; target ready may stall.
// - CPU read finishes only after data is delivered to the CPU.
// - Lost flag is bit 6, write one clears, set on locked error.
package pcib_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] OFF_DIAG_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PCI_ERR     = 8'h04;
  localparam logic [7:0] OFF_SYS_ERR     = 8'h08;
  localparam logic [7:0] OFF_TBASE_ONE   = 8'h0c;
  localparam logic [7:0] OFF_TBASE_TWO   = 8'h10;
  localparam logic [7:0] OFF_EXT_ZERO    = 8'h14;
  localparam logic [7:0] OFF_EXT_ONE     = 8'h18;
  localparam logic [7:0] OFF_FLUSH_ALL   = 8'h1c;
  localparam logic [7:0] OFF_TLB_TAG     = 8'h20;
  localparam logic [7:0] OFF_TLB_DATA    = 8'h40;
  localparam int         TLB_ENTRIES     = 8;

  // ****************************************************************
  // Diagnostic control fields
  // ****************************************************************
  localparam int BIT_MEM_ACK     = 15;
  localparam int BIT_INV_MAP     = 14;
  localparam int BIT_UNCORR_RD   = 13;
  localparam int BIT_CORR_RD     = 12;
  localparam int BIT_NO_TARGET   = 11;
  localparam int BIT_TGT_ABORT   = 10;
  localparam int BIT_IO_PARITY   = 9;
  localparam int BIT_DMA_PARITY  = 8;
  localparam int BIT_LOST        = 6;
  localparam int BIT_RETRY_TMO   = 5;
  localparam int BIT_NO_PAR_CHK  = 4;
  localparam int BIT_NO_CORR_LOG = 3;
  localparam int BIT_TLB_ENABLE  = 0;
  localparam logic [15:0] DIAG_RWC_MASK = 16'hff60;
  localparam logic [15:0] DIAG_RW_MASK  = 16'h001d;
  localparam logic [15:0] PCI_ERR_MASK  = 16'h4f20;
  localparam logic [15:0] SYS_ERR_MASK  = 16'hb000;
  localparam logic [15:0] DIAG_RESET    = 16'h0000;

  // ****************************************************************
  // Commands and codes
  // ****************************************************************
  localparam logic [2:0] SB_FETCH        = 3'h1;
  localparam logic [2:0] SB_FETCH_MODIFY = 3'h2;
  localparam logic [2:0] SB_READ_BLOCK   = 3'h3;
  localparam logic [2:0] IO_ACK_NONE     = 3'h0;
  localparam logic [2:0] IO_ACK_OK       = 3'h1;
  localparam logic [1:0] SPACE_MEM       = 2'h0;
  localparam logic [1:0] SPACE_IO        = 2'h1;
  localparam logic [1:0] SPACE_CFG       = 2'h2;
  localparam logic [3:0] PCI_CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] PCI_CMD_IO_RD   = 4'h2;
  localparam logic [3:0] PCI_CMD_CFG_RD  = 4'ha;
  localparam logic [3:0] PCI_CMD_INT_ACK = 4'h0;
  localparam logic [3:0] PCI_BE_ALL      = 4'h0;
  localparam logic [1:0] RESP_OK         = 2'h0;
  localparam logic [1:0] RESP_ABORT      = 2'h1;
  localparam logic [1:0] RESP_RETRY      = 2'h2;
  localparam logic [1:0] RESP_NO_TARGET  = 2'h3;

  typedef enum logic [2:0] {
    PCIB_IDLE, PCIB_ARB, PCIB_WAIT, PCIB_HOLD, PCIB_DONE, PCIB_RETRY
  } pcib_fsm_e;

  typedef struct packed {
    logic        valid;
    logic [2:0]  cmd;
    logic [33:0] addr;
  } pcib_sb_req_s;

  typedef struct packed {
    logic        valid;
    logic [1:0]  code;
    logic        parity_err;
    logic [31:0] data;
  } pcib_pci_resp_s;

  typedef struct packed {
    logic        valid;
    logic [2:0]  index;
    logic [18:0] tag;
    logic [19:0] page;
  } pcib_tlb_fill_s;

endpackage

// File: src/pcib_bridge.sv
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module pcib_bridge
  import pcib_pkg::*;
(
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           reset,
  // Wishbone register slave
  input  wire logic           wb_cyc,
  input  wire logic           wb_stb,
  input  wire logic           wb_we,
  input  wire logic [7:0]     wb_adr,
  input  wire logic [3:0]     wb_sel,
  input  wire logic [31:0]    wb_dat_w,
  output logic      [31:0]    wb_dat_r,
  output logic                wb_ack,
  // System bus side
  input  wire pcib_sb_req_s   sb_req,
  input  wire logic           cpu_delivered,
  output logic      [2:0]     io_ack_code,
  output logic                cpu_read_busy,
  output logic                cpu_read_preempt,
  // PCI master side
  input  wire logic           pci_grant_n,
  input  wire logic           pci_bus_idle,
  input  wire logic           dma_read_seen,
  input  wire pcib_pci_resp_s pci_resp,
  output logic                pci_request_n,
  output logic                pci_addr_valid,
  output logic      [31:0]    pci_ad_out,
  output logic      [3:0]     pci_cbe_out,
  output logic      [3:0]     pci_cmd_out,
  output logic                pci_master_active,
  output logic                pci_target_ready_hold,
  // Internal data bus and read buffer
  input  wire logic           internal_data_bus_grant,
  output logic                internal_data_bus_request,
  output logic                read_buf_write,
  output logic      [31:0]    read_buf_data,
  output logic                read_buf_error,
  // Error events and map cache fill
  input  wire logic [5:0]     pci_err_evt,
  input  wire logic [31:0]    pci_err_addr,
  input  wire logic [2:0]     sys_err_evt,
  input  wire logic [33:6]    sys_err_addr,
  input  wire pcib_tlb_fill_s tlb_fill,
  // Window and translation control
  output logic      [22:0]    window_base_one,
  output logic      [22:0]    window_base_two,
  output logic      [4:0]     upper_pci_addr_bits,
  output logic                tlb_enable
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    pcib_fsm_e                     fsm;
    logic                          wb_ack;
    logic [31:0]                   wb_dat;
    logic [15:0]                   diag;
    logic [31:0]                   pci_err;
    logic [27:0]                   sys_err;
    logic [22:0]                   tbase_one;
    logic [22:0]                   tbase_two;
    logic [4:0]                    ext_one;
    logic [TLB_ENTRIES-1:0]        entry_valid_flag;
    logic [TLB_ENTRIES-1:0][18:0]  tlb_tag;
    logic [TLB_ENTRIES-1:0][19:0]  tlb_page;
    logic [31:0]                   pend_addr;
    logic [3:0]                    pend_cmd;
    logic [2:0]                    ack_code;
    logic                          busy;
    logic                          preempt;
    logic                          req_n;
    logic                          addr_valid;
    logic                          master_active;
    logic                          idb_req;
    logic                          buf_wr;
    logic [31:0]                   buf_data;
    logic                          buf_err;
    logic                          trdy_hold;
  } pcib_state_s;

  pcib_state_s st;
  pcib_state_s next_st;

  logic        acc;
  logic        wr;
  logic [31:0] wmask;
  logic [31:0] merged;
  logic [31:0] cur;
  logic [15:0] pci_bits;
  logic [15:0] sys_bits;
  logic        pci_locked;
  logic        sys_locked;
  logic        rsp_nodev;
  logic        rsp_abort;
  logic        rsp_parity;

  assign acc   = wb_cyc && wb_stb && !st.wb_ack;
  assign wr    = acc && wb_we;
  assign wmask = {{8{wb_sel[3]}}, {8{wb_sel[2]}},
                  {8{wb_sel[1]}}, {8{wb_sel[0]}}};
  assign pci_locked = |(st.diag & PCI_ERR_MASK);
  assign sys_locked = |(st.diag & SYS_ERR_MASK);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.wb_ack = 1'b0;
    next_st.ack_code = IO_ACK_NONE;
    next_st.preempt = 1'b0;
    next_st.addr_valid = 1'b0;
    next_st.buf_wr = 1'b0;
    rsp_nodev = 1'b0;
    rsp_abort = 1'b0;
    rsp_parity = 1'b0;
    cur = 32'h0;

    // Register read and write. Writes land at the edge that raises ack.
    if (acc) begin
      next_st.wb_ack = 1'b1;
      case (wb_adr)
        OFF_DIAG_CTRL: cur = {16'h0, st.diag & (DIAG_RWC_MASK | DIAG_RW_MASK)};
        OFF_PCI_ERR:   cur = st.pci_err;
        OFF_SYS_ERR:   cur = {st.sys_err, 4'h0};
        OFF_TBASE_ONE: cur = {st.tbase_one, 9'h0};
        OFF_TBASE_TWO: cur = {st.tbase_two, 9'h0};
        OFF_EXT_ZERO:  cur = 32'h0;
        OFF_EXT_ONE:   cur = {st.ext_one, 27'h0};
        default:       cur = 32'h0;
      endcase
      for (int i = 0; i < TLB_ENTRIES; i++) begin
        if (wb_adr == OFF_TLB_TAG + 8'(4 * i)) begin
          cur = {st.tlb_tag[i], st.entry_valid_flag[i], 12'h0};
        end
        if (wb_adr == OFF_TLB_DATA + 8'(4 * i)) begin
          cur = {11'h0, st.tlb_page[i], 1'b0};
        end
      end
      next_st.wb_dat = wb_we ? 32'h0 : cur;
    end
    merged = (cur & ~wmask) | (wb_dat_w & wmask);

    if (wr) begin
      case (wb_adr)
        OFF_DIAG_CTRL: begin
          next_st.diag = st.diag & ~(wb_dat_w[15:0] & wmask[15:0]
                                     & DIAG_RWC_MASK);
          next_st.diag = (next_st.diag & ~DIAG_RW_MASK)
                         | (merged[15:0] & DIAG_RW_MASK);
        end
        OFF_TBASE_ONE: next_st.tbase_one = merged[31:9];
        OFF_TBASE_TWO: next_st.tbase_two = merged[31:9];
        OFF_EXT_ONE:   next_st.ext_one = merged[31:27];
        OFF_FLUSH_ALL: next_st.entry_valid_flag = '0;
        default: ;
      endcase
    end

    // A fill after a flush in the same cycle is a new entry and stays.
    if (tlb_fill.valid) begin
      next_st.entry_valid_flag[tlb_fill.index] = 1'b1;
      next_st.tlb_tag[tlb_fill.index] = tlb_fill.tag;
      next_st.tlb_page[tlb_fill.index] = tlb_fill.page;
    end

    // CPU read sequencing toward PCI.
    case (st.fsm)
      PCIB_IDLE: begin
        if (sb_req.valid) begin
          if (sb_req.cmd == SB_FETCH || sb_req.cmd == SB_FETCH_MODIFY) begin
            next_st.ack_code = IO_ACK_OK;
          end else if (sb_req.cmd == SB_READ_BLOCK && sb_req.addr[33]) begin
            next_st.fsm = PCIB_ARB;
            case (sb_req.addr[32:31])
              SPACE_MEM: begin
                next_st.pend_addr = {st.ext_one, sb_req.addr[26:0]};
                next_st.pend_cmd = PCI_CMD_MEM_RD;
              end
              SPACE_IO: begin
                next_st.pend_addr = sb_req.addr[31:0];
                next_st.pend_cmd = PCI_CMD_IO_RD;
              end
              SPACE_CFG: begin
                next_st.pend_addr = sb_req.addr[31:0];
                next_st.pend_cmd = PCI_CMD_CFG_RD;
              end
              default: begin
                next_st.pend_addr = sb_req.addr[31:0];
                next_st.pend_cmd = PCI_CMD_INT_ACK;
              end
            endcase
          end
        end
      end
      PCIB_ARB: begin
        // Giving the CPU read back keeps PCI DMA reads from deadlocking.
        if (dma_read_seen) begin
          next_st.fsm = PCIB_IDLE;
          next_st.preempt = 1'b1;
        end else if (!pci_grant_n) begin
          next_st.fsm = PCIB_WAIT;
          next_st.addr_valid = 1'b1;
          next_st.idb_req = 1'b1;
        end
      end
      PCIB_WAIT: begin
        if (pci_resp.valid) begin
          if (pci_resp.code == RESP_RETRY) begin
            next_st.idb_req = 1'b0;
            next_st.fsm = PCIB_RETRY;
          end else begin
            rsp_nodev = pci_resp.code == RESP_NO_TARGET;
            rsp_abort = pci_resp.code == RESP_ABORT;
            rsp_parity = pci_resp.parity_err && !st.diag[BIT_NO_PAR_CHK];
            next_st.buf_data = pci_resp.data;
            next_st.buf_err = rsp_nodev || rsp_abort || rsp_parity;
            next_st.fsm = PCIB_HOLD;
          end
        end
      end
      PCIB_HOLD: begin
        if (internal_data_bus_grant) begin
          next_st.buf_wr = 1'b1;
          next_st.idb_req = 1'b0;
          next_st.fsm = PCIB_DONE;
        end
      end
      PCIB_DONE: begin
        if (cpu_delivered) begin
          next_st.fsm = PCIB_IDLE;
        end
      end
      PCIB_RETRY: begin
        if (pci_bus_idle) begin
          next_st.fsm = PCIB_ARB;
        end
      end
      default: next_st.fsm = PCIB_IDLE;
    endcase

    next_st.req_n = !(next_st.fsm == PCIB_ARB && pci_grant_n);
    next_st.master_active = next_st.fsm == PCIB_WAIT;
    next_st.trdy_hold = next_st.fsm == PCIB_HOLD;
    next_st.busy = next_st.fsm != PCIB_IDLE;

    // Error capture comes last so a new error beats a software clear.
    pci_bits = 16'h0;
    pci_bits[BIT_NO_TARGET]  = pci_err_evt[5] || rsp_nodev;
    pci_bits[BIT_TGT_ABORT]  = pci_err_evt[4] || rsp_abort;
    pci_bits[BIT_IO_PARITY]  = pci_err_evt[3] || rsp_parity;
    pci_bits[BIT_DMA_PARITY] = pci_err_evt[2];
    pci_bits[BIT_INV_MAP]    = pci_err_evt[1];
    pci_bits[BIT_RETRY_TMO]  = pci_err_evt[0];
    sys_bits = 16'h0;
    sys_bits[BIT_MEM_ACK]   = sys_err_evt[2];
    sys_bits[BIT_UNCORR_RD] = sys_err_evt[1];
    sys_bits[BIT_CORR_RD]   = sys_err_evt[0] && !st.diag[BIT_NO_CORR_LOG];
    next_st.diag = next_st.diag | pci_bits | sys_bits;
    if (|pci_bits) begin
      if (pci_locked) begin
        next_st.diag[BIT_LOST] = 1'b1;
      end else begin
        // Full 32 bits are kept; software reads the valid subset.
        next_st.pci_err = |pci_err_evt ? pci_err_addr
                                       : st.pend_addr;
      end
    end
    if (|sys_bits) begin
      if (sys_locked) begin
        next_st.diag[BIT_LOST] = 1'b1;
      end else begin
        next_st.sys_err = sys_err_addr;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
      st.diag <= DIAG_RESET;
      st.req_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wb_dat_r                  = st.wb_dat;
  assign wb_ack                    = st.wb_ack;
  assign io_ack_code               = st.ack_code;
  assign cpu_read_busy             = st.busy;
  assign cpu_read_preempt          = st.preempt;
  assign pci_request_n             = st.req_n;
  assign pci_addr_valid            = st.addr_valid;
  assign pci_ad_out                = st.pend_addr;
  assign pci_cbe_out               = PCI_BE_ALL;
  assign pci_cmd_out               = st.pend_cmd;
  assign pci_master_active         = st.master_active;
  assign pci_target_ready_hold     = st.trdy_hold;
  assign internal_data_bus_request = st.idb_req;
  assign read_buf_write            = st.buf_wr;
  assign read_buf_data             = st.buf_data;
  assign read_buf_error            = st.buf_err;
  assign window_base_one           = st.tbase_one;
  assign window_base_two           = st.tbase_two;
  assign upper_pci_addr_bits       = st.ext_one;
  assign tlb_enable                = st.diag[BIT_TLB_ENABLE];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_fetch_ack: assert property (
    (st.fsm == PCIB_IDLE && sb_req.valid && sb_req.cmd == SB_FETCH)
    |=> io_ack_code == IO_ACK_OK && !cpu_read_busy)
    else $error("Fetch not acknowledged with OK.");

  a_parked_no_req: assert property (
    (st.fsm == PCIB_ARB && !pci_grant_n) |=> pci_request_n
    && (pci_addr_valid || cpu_read_preempt))
    else $error("Request raised while bus parked.");

  a_pci_lock_hold: assert property (
    (pci_locked && |pci_err_evt) |=> $stable(st.pci_err) && st.diag[BIT_LOST])
    else $error("Locked PCI error address changed.");

  a_sys_low_zero: assert property (
    (acc && !wb_we && wb_adr == OFF_SYS_ERR) |=> wb_ack && wb_dat_r[3:0] == 4'h0)
    else $error("System error address low bits not zero.");

  a_ext_zero_read: assert property (
    (acc && !wb_we && wb_adr == OFF_EXT_ZERO) |=> wb_dat_r == 32'h0)
    else $error("Extension zero read not zero.");

  a_flush_all: assert property (
    (wr && wb_adr == OFF_FLUSH_ALL && !tlb_fill.valid)
    |=> st.entry_valid_flag == '0)
    else $error("Flush left a valid entry.");

  a_retry_drop: assert property (
    (st.fsm == PCIB_WAIT && pci_resp.valid && pci_resp.code == RESP_RETRY)
    |=> !internal_data_bus_request && st.fsm == PCIB_RETRY)
    else $error("Retry did not drop data bus request.");

  a_hold_move: assert property (
    (st.fsm == PCIB_HOLD && internal_data_bus_grant)
    |=> read_buf_write && !internal_data_bus_request ##1 !read_buf_write)
    else $error("Held read data not moved on grant.");

  a_grant_drive: assert property (
    (st.fsm == PCIB_ARB && !pci_grant_n && !dma_read_seen)
    |=> pci_addr_valid && internal_data_bus_request && pci_master_active)
    else $error("Grant did not drive address and request.");

endmodule
`default_nettype wire

// File: bench/pcib_pci_target.sv
`timescale 1ns/1ps
`default_nettype none
module pcib_pci_target
  import pcib_pkg::*;
#(
  parameter logic [31:0] DATA = 32'h5a5a_0f0f
)
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Behaviour chosen by the bench
  input  wire logic       parked,
  input  wire logic       hold,
  input  wire logic [1:0] code,
  input  wire logic       perr,
  // PCI side
  input  wire logic       pci_request_n,
  input  wire logic       pci_addr_valid,
  output var  logic       pci_grant_n,
  output var  pcib_pci_resp_s pci_resp
);
  logic [1:0] wait_cnt;

  // Data turns over every idle cycle so a stale word never passes as fresh.
  always_ff @(posedge ref_clk) begin
    pci_resp.valid <= 1'b0;
    pci_resp.data  <= ~pci_resp.data;
    if (reset) begin
      pci_grant_n <= 1'b1;
      wait_cnt    <= 2'h0;
    end else begin
      pci_grant_n <= parked ? 1'b0 : (hold | pci_request_n);
      if (pci_addr_valid) begin
        wait_cnt <= 2'h2;
      end else if (wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
      if (wait_cnt == 2'h1) begin
        pci_resp <= '{1'b1, code, perr, DATA};
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/pcib_bridge_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcib_bridge_tb_top
  import pcib_pkg::*;
;
  localparam logic [31:0] RD = 32'h5a5a_0f0f;
  logic ref_clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, cpu_delivered;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, cmd_out, cbe;
  logic [31:0] wb_dat_w, wb_dat_r, ad_out, buf_data, pci_err_addr;
  logic [2:0] io_ack, sys_err_evt;
  logic busy, preempt, grant_n, req_n, addr_v, tr_hold, idb_grant, idb_req;
  logic dma_rd, buf_wr, buf_err, parked, hold, perr, bus_idle, m_act, tlb_en;
  logic [1:0] code;
  logic [5:0] pci_err_evt;
  logic [33:6] sys_err_addr;
  logic [22:0] base_one, base_two;
  logic [4:0] ext_bits;
  pcib_sb_req_s sb_req;
  pcib_pci_resp_s pci_resp;
  pcib_tlb_fill_s tlb_fill;
  int bad_count = 0;
  int checked = 0;

  pcib_bridge i_dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .sb_req(sb_req), .cpu_delivered(cpu_delivered), .io_ack_code(io_ack),
    .cpu_read_busy(busy), .cpu_read_preempt(preempt),
    .pci_grant_n(grant_n), .pci_bus_idle(bus_idle), .dma_read_seen(dma_rd),
    .pci_resp(pci_resp), .pci_request_n(req_n), .pci_addr_valid(addr_v),
    .pci_ad_out(ad_out), .pci_cbe_out(cbe), .pci_cmd_out(cmd_out),
    .pci_master_active(m_act), .pci_target_ready_hold(tr_hold),
    .internal_data_bus_grant(idb_grant),
    .internal_data_bus_request(idb_req), .read_buf_write(buf_wr),
    .read_buf_data(buf_data), .read_buf_error(buf_err),
    .pci_err_evt(pci_err_evt), .pci_err_addr(pci_err_addr),
    .sys_err_evt(sys_err_evt), .sys_err_addr(sys_err_addr),
    .tlb_fill(tlb_fill), .window_base_one(base_one),
    .window_base_two(base_two), .upper_pci_addr_bits(ext_bits),
    .tlb_enable(tlb_en));
  pcib_pci_target #(.DATA(RD)) i_tgt (.ref_clk(ref_clk), .reset(reset),
    .parked(parked), .hold(hold), .code(code), .perr(perr),
    .pci_request_n(req_n), .pci_addr_valid(addr_v),
    .pci_grant_n(grant_n), .pci_resp(pci_resp));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    input string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, q & m, e);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    rd(OFF_EXT_ONE, 32'h0, '1, "ext one reset");
    rd(OFF_TLB_TAG, 32'h0, 32'h1000, "tag valid reset");
    wr(OFF_EXT_ZERO, '1);
    rd(OFF_EXT_ZERO, 32'h0, '1, "ext zero");
    wr(OFF_EXT_ONE, '1);
    rd(OFF_EXT_ONE, 32'hf800_0000, '1, "ext one");
    chk("ext bits", ext_bits, 32'h1f);
    wr(OFF_TBASE_ONE, '1);
    rd(OFF_TBASE_ONE, 32'hffff_fe00, '1, "base");
    chk("base out", base_one, 32'h7f_ffff);
    wr(OFF_TBASE_TWO, 32'h8000_0200);
    chk("base two", base_two, 32'h40_0001);
    wr(8'hfc, '1);
    rd(8'hfc, 32'h0, '1, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_err(input logic [31:0] a, b);
    @(posedge ref_clk);
    pci_err_evt <= 6'h20;
    pci_err_addr <= a;
    sys_err_evt <= 3'h4;
    sys_err_addr <= a[27:0];
    @(posedge ref_clk);
    pci_err_evt <= 6'h01;
    pci_err_addr <= b;
    sys_err_evt <= 3'h1;
    sys_err_addr <= b[27:0];
    @(posedge ref_clk);
    pci_err_evt <= 6'h0;
    sys_err_evt <= 3'h0;
    rd(OFF_PCI_ERR, a, '1, "pci err");
    rd(OFF_SYS_ERR, {a[27:0], 4'h0}, '1, "sys err");
    rd(OFF_DIAG_CTRL, 32'h9860, 32'hff60, "flags lost");
    wr(OFF_DIAG_CTRL, 32'hff60);
    rd(OFF_DIAG_CTRL, 32'h0, 32'hff60, "cleared");
    wr(OFF_DIAG_CTRL, 32'h1);
    chk("tlb enable", tlb_en, 32'h1);
    $display("test errlog done");
  endtask
  task automatic t_tlb;
    @(posedge ref_clk);
    tlb_fill <= '{1'b1, 3'h3, 19'h5_a5a5, 20'h3_c3c3};
    @(posedge ref_clk);
    tlb_fill.valid <= 1'b0;
    rd(OFF_TLB_TAG + 8'h0c, 32'hb4b4_b000, '1, "tag");
    rd(OFF_TLB_DATA + 8'h0c, 32'h0007_8786, '1, "data");
    wr(OFF_FLUSH_ALL, 32'h0);
    rd(OFF_TLB_TAG + 8'h0c, 32'h0, 32'h1000, "flushed");
    $display("test tlb done");
  endtask
  task automatic t_fetch(input logic [2:0] c);
    @(posedge ref_clk);
    sb_req <= '{1'b1, c, 34'h0};
    @(posedge ref_clk);
    sb_req.valid <= 1'b0;
    @(posedge ref_clk);
    chk("fetch ack", io_ack, IO_ACK_OK);
    chk("fetch busy", busy, 32'h0);
    $display("test fetch done");
  endtask
  task automatic t_read(input logic [1:0] sp, cd, input logic pe, pk,
                        input logic [3:0] ec);
    logic rq = 1'b0;
    code <= cd;
    bus_idle <= cd != RESP_RETRY;
    perr <= pe;
    parked <= pk;
    idb_grant <= 1'b0;
    repeat (3) @(posedge ref_clk);
    sb_req <= '{1'b1, SB_READ_BLOCK, {1'b1, sp, 31'h100}};
    @(posedge ref_clk);
    sb_req.valid <= 1'b0;
    do begin
      @(posedge ref_clk);
      if (req_n === 1'b0) rq = 1'b1;
    end while (addr_v !== 1'b1);
    if (cd == RESP_RETRY) begin
      while (idb_req !== 1'b0) @(posedge ref_clk);
      chk("retry wait", req_n, 32'h1);
      bus_idle <= 1'b1;
      code <= RESP_OK;
      do begin
        @(posedge ref_clk);
      end while (addr_v !== 1'b1);
    end
    chk("request", rq, !pk);
    chk("active", m_act, 32'h1);
    chk("byte enables", cbe, 32'h0);
    chk("command", cmd_out, ec);
    chk("idb request", idb_req, 32'h1);
    if (sp == SPACE_MEM) chk("upper ad", ad_out[31:27], 32'h1f);
    do begin
      @(posedge ref_clk);
    end while (tr_hold !== 1'b1);
    chk("held", tr_hold, 32'h1);
    chk("released", req_n, 32'h1);
    chk("inactive", m_act, 32'h0);
    idb_grant <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (buf_wr !== 1'b1);
    chk("buf error", buf_err, (code != RESP_OK) || pe);
    if (code == RESP_OK && !pe) chk("buf data", buf_data, RD);
    chk("idb dropped", idb_req, 32'h0);
    chk("still busy", busy, 32'h1);
    cpu_delivered <= 1'b1;
    @(posedge ref_clk);
    cpu_delivered <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("done", busy, 32'h0);
    parked <= 1'b0;
    $display("test read done");
  endtask
  task automatic t_preempt;
    hold <= 1'b1;
    @(posedge ref_clk);
    sb_req <= '{1'b1, SB_READ_BLOCK, {1'b1, SPACE_IO, 31'h40}};
    @(posedge ref_clk);
    sb_req.valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    dma_rd <= 1'b1;
    @(posedge ref_clk);
    dma_rd <= 1'b0;
    @(posedge ref_clk);
    chk("preempt", preempt, 32'h1);
    chk("preempt idle", busy, 32'h0);
    hold <= 1'b0;
    $display("test preempt done");
  endtask

  // ****************************************************************
  // Clock, sequence and watchdog
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    {reset, hold, bus_idle} = 3'b111;
    {wb_cyc, wb_stb, wb_we, cpu_delivered, dma_rd, idb_grant} = '0;
    {parked, perr, code, wb_adr, wb_dat_w, pci_err_addr} = '0;
    {pci_err_evt, sys_err_evt, sys_err_addr, sb_req, tlb_fill} = '0;
    wb_sel = 4'hf;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    hold <= 1'b0;
    t_regs;
    t_err(32'h1234_5678, 32'h0bad_0bad);
    t_tlb;
    t_fetch(SB_FETCH);
    t_fetch(SB_FETCH_MODIFY);
    t_read(SPACE_MEM, RESP_OK, 1'b0, 1'b0, PCI_CMD_MEM_RD);
    t_read(SPACE_IO, RESP_RETRY, 1'b0, 1'b0, PCI_CMD_IO_RD);
    t_read(SPACE_IO, RESP_OK, 1'b1, 1'b1, PCI_CMD_IO_RD);
    t_read(SPACE_CFG, RESP_ABORT, 1'b0, 1'b0, PCI_CMD_CFG_RD);
    t_read(2'h3, RESP_NO_TARGET, 1'b0, 1'b0, PCI_CMD_INT_ACK);
    t_preempt;
    test_done;
  end
  // The whole sequence needs a few hundred cycles; this is ample margin.
  initial begin
    #2_000_000;
    bad_count++;
    test_done;
  end
endmodule
`default_nettype wire
